// file: pcrs_consts.vh
// Constants for the power-up clock ratio strap block.
// Included by the top design file only; definitions only.
`ifndef PCRS_CONSTS_VH
`define PCRS_CONSTS_VH

// Platform ratio strap codes
`define PCRS_PLAT_16  4'h0
`define PCRS_PLAT_2   4'h2
`define PCRS_PLAT_3   4'h3
`define PCRS_PLAT_4   4'h4
`define PCRS_PLAT_5   4'h5
`define PCRS_PLAT_6   4'h6
`define PCRS_PLAT_8   4'h8
`define PCRS_PLAT_9   4'h9
`define PCRS_PLAT_10  4'ha
`define PCRS_PLAT_12  4'hc

// Core ratio codes, ratio in halves
`define PCRS_CORE_2_1 2'h0
`define PCRS_CORE_5_2 2'h1
`define PCRS_CORE_3_1 2'h2
`define PCRS_CORE_7_2 2'h3
`define PCRS_HALF_2_1 4'h4
`define PCRS_HALF_5_2 4'h5
`define PCRS_HALF_3_1 4'h6
`define PCRS_HALF_7_2 4'h7

// Reset values
`define PCRS_RST_PLAT_MULT 5'h00
`define PCRS_RST_CODE4     4'h0
`define PCRS_RST_CODE2     2'h0
`define PCRS_RST_HALF      4'h0
`define PCRS_RST_FLAG      1'h0
`define PCRS_RST_HARD_OUT  1'h1

// Multiplier value that marks a reserved platform code
`define PCRS_MULT_NONE     5'h00

`endif

// file: pcrs_plat_div.v
// Platform clock enable generator: one pulse every mult cycles of the input clock.
// Assumes mult is stable while enabled and nonzero.
`default_nettype none

module pcrs_plat_div (
   // Clock and reset
   input  wire       clk,
   input  wire       rst,
   // Control
   input  wire       en,
   input  wire [4:0] mult,
   // Tick
   output reg        tick
);

   reg [4:0] cnt_q;

   always @(posedge clk) begin
      if (rst || !en) begin
         cnt_q <= 5'h00;
         tick  <= 1'b0;
      end else if (cnt_q >= mult - 5'h01) begin
         cnt_q <= 5'h00;
         tick  <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 5'h01;
         tick  <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// file: pcrs_top.v
// Power-up clock ratio strap capture and decode.
// Assumes straps are stable, board-driven levels while SRST is high.
// Assumes HARD_RESET_INPUT already merges the debug port and board resets.
// Tick outputs are enables at the platform rate, not clocks.
//
// Behaviour
// RQ1: Capture four ratio straps at power-up; they select platform multiplier.
// RQ2: Board pulls platform straps to levels; no default ratio exists.
// RQ3: Code 0000 means 16:1; codes 0010 to 0110 mean 2:1 to 6:1.
// RQ4: Codes 1000,1001,1010,1100 mean 8,9,10,12:1; other codes reserved.
// RQ5: Capture address latch and gp line two straps as core ratio code.
// RQ6: Core code 00,01,10,11 give 2:1, 5:2, 3:1, 7:2 core to platform.
// RQ7: Platform clock times second-level cache, memory data rate, core bus.
// RQ8: Soft reset raises machine check to core, not a hard reset.
// RQ9: Debug port asserts hard reset or test reset on its own; code has no test reset, only HARD_RESET_INPUT to HARD_RESET_OUT.
// RQ10: Ratios latched once at power-up, held until next power-up reset; code also clears and resamples them on HARD_RESET_INPUT.
`include "pcrs_consts.vh"
`default_nettype none

module pcrs_top (
   // Clock and power-up reset
   input  wire       REF_CLK,
   input  wire       SRST,
   // Strap inputs
   input  wire [3:0] LOCAL_ADDRESS_RATIO_STRAPS,
   input  wire       ADDRESS_LATCH_STRAP,
   input  wire       GP_LINE_TWO_STRAP,
   // Reset inputs
   input  wire       SOFT_RESET_INPUT,
   input  wire       HARD_RESET_INPUT,
   // Ratio outputs
   output reg  [4:0] PLAT_MULT,
   output reg  [3:0] CORE_HALF_RATIO,
   output reg        PLAT_RESERVED,
   output reg        RATIOS_VALID,
   // Platform clock timing
   output reg        PLATFORM_BUS_CLOCK_TICK,
   output reg        CACHE_TICK,
   output reg        MEM_RATE_TICK,
   output reg        CORE_BUS_TICK,
   // Reset outcomes
   output reg        MACHINE_CHECK,
   output reg        HARD_RESET_OUT
);

   // Power-up latch states
   localparam [1:0] ST_SAMPLE = 2'h0;
   localparam [1:0] ST_HOLD   = 2'h1;

   // Captured strap codes and latch state
   reg  [3:0] plat_code_q;
   reg  [3:0] plat_code_d;
   reg  [1:0] core_code_q;
   reg  [1:0] core_code_d;
   reg  [1:0] state_q;
   reg  [1:0] state_d;
   // Next values of the registered outputs
   reg  [4:0] plat_mult_d;
   reg  [3:0] core_half_d;
   reg        plat_rsvd_d;
   reg        ratios_valid_d;
   reg        plat_tick_d;
   reg        cache_tick_d;
   reg        mem_tick_d;
   reg        core_tick_d;
   reg        mcheck_d;
   reg        hard_out_d;
   // Divider tick and merged reset
   wire       tick;
   wire       hold_rst;

   function [4:0] plat_mult_of;
      input [3:0] code;
      begin
         case (code)
            `PCRS_PLAT_16: plat_mult_of = 5'h10; // RQ3
            `PCRS_PLAT_2:  plat_mult_of = 5'h02;
            `PCRS_PLAT_3:  plat_mult_of = 5'h03;
            `PCRS_PLAT_4:  plat_mult_of = 5'h04;
            `PCRS_PLAT_5:  plat_mult_of = 5'h05;
            `PCRS_PLAT_6:  plat_mult_of = 5'h06;
            `PCRS_PLAT_8:  plat_mult_of = 5'h08; // RQ4
            `PCRS_PLAT_9:  plat_mult_of = 5'h09;
            `PCRS_PLAT_10: plat_mult_of = 5'h0a;
            `PCRS_PLAT_12: plat_mult_of = 5'h0c;
            default:       plat_mult_of = `PCRS_MULT_NONE; // RQ4
         endcase
      end
   endfunction

   function [3:0] core_half_of;
      input [1:0] code;
      begin
         case (code)
            `PCRS_CORE_2_1: core_half_of = `PCRS_HALF_2_1; // RQ6
            `PCRS_CORE_5_2: core_half_of = `PCRS_HALF_5_2;
            `PCRS_CORE_3_1: core_half_of = `PCRS_HALF_3_1;
            `PCRS_CORE_7_2: core_half_of = `PCRS_HALF_7_2;
            default:        core_half_of = `PCRS_HALF_7_2;
         endcase
      end
   endfunction

   // Reserved platform codes carry no ratio
   function plat_reserved_of;
      input [3:0] code;
      begin
         plat_reserved_of = (plat_mult_of(code) == `PCRS_MULT_NONE); // RQ4
      end
   endfunction

   // Hard reset also clears the latched ratios so they are resampled
   assign hold_rst = SRST | HARD_RESET_INPUT; // RQ9

   // Straps follow the pins while reset is held, freeze at release
   always @* begin
      plat_code_d = plat_code_q;
      core_code_d = core_code_q;
      if (hold_rst) begin
         plat_code_d = LOCAL_ADDRESS_RATIO_STRAPS; // RQ1
         core_code_d = {ADDRESS_LATCH_STRAP, GP_LINE_TWO_STRAP}; // RQ5
      end
   end

   // One decode cycle after release, then hold until the next reset
   always @* begin
      case (state_q)
         ST_SAMPLE: state_d = ST_HOLD;
         ST_HOLD:   state_d = ST_HOLD; // RQ10
         default:   state_d = ST_SAMPLE;
      endcase
      if (hold_rst) begin
         state_d = ST_SAMPLE;
      end
   end

   always @(posedge REF_CLK) begin
      plat_code_q <= plat_code_d;
      core_code_q <= core_code_d;
      state_q     <= state_d;
   end

   // Decode in the first cycle after release, then hold
   always @* begin
      plat_mult_d    = PLAT_MULT;
      core_half_d    = CORE_HALF_RATIO;
      plat_rsvd_d    = PLAT_RESERVED;
      ratios_valid_d = RATIOS_VALID;
      case (state_q)
         ST_SAMPLE: begin
            plat_mult_d    = plat_mult_of(plat_code_q); // RQ1
            core_half_d    = core_half_of(core_code_q); // RQ5
            plat_rsvd_d    = plat_reserved_of(plat_code_q); // RQ2
            ratios_valid_d = !plat_reserved_of(plat_code_q);
         end
         ST_HOLD: begin
            ratios_valid_d = RATIOS_VALID; // RQ10
         end
         default: begin
            ratios_valid_d = `PCRS_RST_FLAG;
         end
      endcase
      if (hold_rst) begin
         plat_mult_d    = `PCRS_RST_PLAT_MULT;
         core_half_d    = `PCRS_RST_HALF;
         plat_rsvd_d    = `PCRS_RST_FLAG;
         ratios_valid_d = `PCRS_RST_FLAG;
      end
   end

   always @(posedge REF_CLK) begin
      PLAT_MULT       <= plat_mult_d;
      CORE_HALF_RATIO <= core_half_d;
      PLAT_RESERVED   <= plat_rsvd_d;
      RATIOS_VALID    <= ratios_valid_d;
   end

   // Counts input clocks per platform clock
   pcrs_plat_div u_div (
      .clk  (REF_CLK),
      .rst  (hold_rst),
      .en   (RATIOS_VALID),
      .mult (PLAT_MULT),
      .tick (tick)
   );

   // Platform clock drives cache, memory rate and core bus timing
   always @* begin
      plat_tick_d  = tick; // RQ7
      cache_tick_d = tick; // RQ7
      mem_tick_d   = tick; // RQ7
      core_tick_d  = tick; // RQ7
      if (hold_rst) begin
         plat_tick_d  = `PCRS_RST_FLAG;
         cache_tick_d = `PCRS_RST_FLAG;
         mem_tick_d   = `PCRS_RST_FLAG;
         core_tick_d  = `PCRS_RST_FLAG;
      end
   end

   always @(posedge REF_CLK) begin
      PLATFORM_BUS_CLOCK_TICK <= plat_tick_d;
      CACHE_TICK              <= cache_tick_d;
      MEM_RATE_TICK           <= mem_tick_d;
      CORE_BUS_TICK           <= core_tick_d;
   end

   // Soft reset gives machine check, never hard reset
   always @* begin
      mcheck_d   = SOFT_RESET_INPUT; // RQ8
      hard_out_d = HARD_RESET_INPUT; // RQ9
      if (SRST) begin
         mcheck_d   = `PCRS_RST_FLAG;
         hard_out_d = `PCRS_RST_HARD_OUT;
      end
   end

   always @(posedge REF_CLK) begin
      MACHINE_CHECK  <= mcheck_d;
      HARD_RESET_OUT <= hard_out_d;
   end

endmodule

`default_nettype wire

// file: pcrs_monitor.sv
// Port checker for pcrs_top.
// Bound from the bench; one clock, SRST synchronous.
`default_nettype none
module pcrs_monitor (
   input wire logic       REF_CLK, SRST, ADDRESS_LATCH_STRAP, GP_LINE_TWO_STRAP,
   input wire logic       SOFT_RESET_INPUT, HARD_RESET_INPUT, PLAT_RESERVED, RATIOS_VALID,
   input wire logic       PLATFORM_BUS_CLOCK_TICK, CACHE_TICK, MEM_RATE_TICK, CORE_BUS_TICK,
   input wire logic       MACHINE_CHECK, HARD_RESET_OUT,
   input wire logic [3:0] LOCAL_ADDRESS_RATIO_STRAPS, CORE_HALF_RATIO,
   input wire logic [4:0] PLAT_MULT
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (SRST);
   wire tk = PLATFORM_BUS_CLOCK_TICK;
   wire [3:0] ls = LOCAL_ADDRESS_RATIO_STRAPS;
   cap_plat_a: assert property ($fell(SRST) && !HARD_RESET_INPUT |-> ##2 PLAT_RESERVED ||
      PLAT_MULT == (|$past(ls, 3) ? {1'b0, $past(ls, 3)} : 5'h10)) else $error("plat capture");
   plat_set_a: assert property (RATIOS_VALID |-> !PLAT_RESERVED && PLAT_MULT inside
      {5'h2, 5'h3, 5'h4, 5'h5, 5'h6, 5'h8, 5'h9, 5'ha, 5'hc, 5'h10}) else $error("plat set");
   rsvd_code_a: assert property (PLAT_RESERVED |-> PLAT_MULT == 5'h0 && !RATIOS_VALID && !tk)
      else $error("reserved code");
   core_map_a: assert property ($fell(SRST) && !HARD_RESET_INPUT |-> ##2 PLAT_RESERVED ||
      CORE_HALF_RATIO == 4'h4 + $past({ADDRESS_LATCH_STRAP, GP_LINE_TWO_STRAP}, 3))
      else $error("core ratio");
   ratio_hold_a: assert property (RATIOS_VALID && !HARD_RESET_INPUT |=> $stable(PLAT_MULT)
      && $stable(CORE_HALF_RATIO)) else $error("ratio hold");
   tick_period_a: assert property (tk && PLAT_MULT == 5'h4 |=> !tk [*3] ##1 tk)
      else $error("tick period");
   tick_fanout_a: assert property (CACHE_TICK == tk && MEM_RATE_TICK == tk
      && CORE_BUS_TICK == tk) else $error("tick fanout");
   soft_mcheck_a: assert property (SOFT_RESET_INPUT && !HARD_RESET_INPUT |=> MACHINE_CHECK
      && !HARD_RESET_OUT) else $error("machine check");
   cover property (PLAT_RESERVED);
   cover property (tk);
   cover property (MACHINE_CHECK);
endmodule
`default_nettype wire

// file: pcrs_board.sv
// Board model: strap pulls and debug-port hard reset.
`default_nettype none
module pcrs_board (
   input  wire logic [5:0] code,
   input  wire logic       dbg_rst,
   output wire logic [5:0] straps,
   output wire logic       hard_rst
);
   timeunit 1ns;
   timeprecision 1ps;
   assign straps = code;
   assign hard_rst = dbg_rst;
endmodule
`default_nettype wire

// file: pcrs_top_bench.sv
// Bench for pcrs_top; inputs change on falling edges.
`default_nettype none
module pcrs_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic REF_CLK = 1'b0, SRST = 1'b1, SOFT_RESET_INPUT = 1'b0, dbg = 1'b0;
   logic [5:0] code = 6'h0;
   wire [3:0] LOCAL_ADDRESS_RATIO_STRAPS, CORE_HALF_RATIO;
   wire [4:0] PLAT_MULT;
   wire ADDRESS_LATCH_STRAP, GP_LINE_TWO_STRAP, HARD_RESET_INPUT, PLAT_RESERVED, RATIOS_VALID,
      PLATFORM_BUS_CLOCK_TICK, CACHE_TICK, MEM_RATE_TICK, CORE_BUS_TICK, MACHINE_CHECK,
      HARD_RESET_OUT;
   int err_total = 0, compares = 0;
   always #2.5 REF_CLK = ~REF_CLK;
   pcrs_board i_brd (.code(code), .dbg_rst(dbg), .hard_rst(HARD_RESET_INPUT),
      .straps({LOCAL_ADDRESS_RATIO_STRAPS, ADDRESS_LATCH_STRAP, GP_LINE_TWO_STRAP}));
   pcrs_top i_dut (.REF_CLK(REF_CLK), .SRST(SRST),
      .LOCAL_ADDRESS_RATIO_STRAPS(LOCAL_ADDRESS_RATIO_STRAPS),
      .ADDRESS_LATCH_STRAP(ADDRESS_LATCH_STRAP), .GP_LINE_TWO_STRAP(GP_LINE_TWO_STRAP),
      .SOFT_RESET_INPUT(SOFT_RESET_INPUT), .HARD_RESET_INPUT(HARD_RESET_INPUT),
      .PLAT_MULT(PLAT_MULT), .CORE_HALF_RATIO(CORE_HALF_RATIO),
      .PLAT_RESERVED(PLAT_RESERVED), .RATIOS_VALID(RATIOS_VALID),
      .PLATFORM_BUS_CLOCK_TICK(PLATFORM_BUS_CLOCK_TICK), .CACHE_TICK(CACHE_TICK),
      .MEM_RATE_TICK(MEM_RATE_TICK), .CORE_BUS_TICK(CORE_BUS_TICK),
      .MACHINE_CHECK(MACHINE_CHECK), .HARD_RESET_OUT(HARD_RESET_OUT));
   task automatic chk(input string n, input logic [4:0] exp, got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic pwr(input logic [5:0] c);
      @(negedge REF_CLK);
      code = c;
      SRST = 1'b1;
      repeat (3) @(negedge REF_CLK);
      SRST = 1'b0;
      repeat (3) @(negedge REF_CLK);
   endtask
   task automatic t_codes();
      logic [15:0] rm = 16'he882;
      for (int i = 0; i < 16; i++) begin
         pwr(6'(i * 4 + i % 4));
         chk("mult", rm[i] ? 5'h0 : (i == 0 ? 5'h10 : 5'(i)), PLAT_MULT);
         chk("valid", {4'h0, ~rm[i]}, {4'h0, RATIOS_VALID});
         chk("rsvd", {4'h0, rm[i]}, {4'h0, PLAT_RESERVED});
         if (!rm[i]) chk("core", 5'h4 + 5'(i % 4), {1'b0, CORE_HALF_RATIO});
      end
      $display("codes test done");
   endtask
   task automatic t_hold();
      pwr(6'h27);
      code = 6'h0d;
      repeat (5) @(negedge REF_CLK);
      chk("held", 5'h9, PLAT_MULT);
      dbg = 1'b1;
      @(negedge REF_CLK);
      chk("hard_out", 5'h1, {4'h0, HARD_RESET_OUT});
      dbg = 1'b0;
      repeat (3) @(negedge REF_CLK);
      chk("resampled", 5'h3, PLAT_MULT);
      $display("hold test done");
   endtask
   task automatic t_run();
      int n = 0;
      pwr(6'h10);
      repeat (40) begin
         @(negedge REF_CLK);
         n += PLATFORM_BUS_CLOCK_TICK;
      end
      chk("ticks", 5'ha, 5'(n));
      SOFT_RESET_INPUT = 1'b1;
      @(negedge REF_CLK);
      chk("mcheck", 5'h1, {4'h0, MACHINE_CHECK});
      chk("no_hard", 5'h0, {4'h0, HARD_RESET_OUT});
      SOFT_RESET_INPUT = 1'b0;
      $display("run test done");
   endtask
   task automatic complete_run();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      t_codes();
      t_hold();
      t_run();
      complete_run();
   end
   initial begin
      #5000;
      err_total++;
      complete_run();
   end
endmodule
bind pcrs_top pcrs_monitor i_mon (.REF_CLK(REF_CLK), .SRST(SRST),
   .LOCAL_ADDRESS_RATIO_STRAPS(LOCAL_ADDRESS_RATIO_STRAPS),
   .ADDRESS_LATCH_STRAP(ADDRESS_LATCH_STRAP), .GP_LINE_TWO_STRAP(GP_LINE_TWO_STRAP),
   .SOFT_RESET_INPUT(SOFT_RESET_INPUT), .HARD_RESET_INPUT(HARD_RESET_INPUT),
   .PLAT_MULT(PLAT_MULT), .CORE_HALF_RATIO(CORE_HALF_RATIO),
   .PLAT_RESERVED(PLAT_RESERVED), .RATIOS_VALID(RATIOS_VALID),
   .PLATFORM_BUS_CLOCK_TICK(PLATFORM_BUS_CLOCK_TICK), .CACHE_TICK(CACHE_TICK),
   .MEM_RATE_TICK(MEM_RATE_TICK), .CORE_BUS_TICK(CORE_BUS_TICK),
   .MACHINE_CHECK(MACHINE_CHECK), .HARD_RESET_OUT(HARD_RESET_OUT));
`default_nettype wire
